// >>> hw/coding_pkg.sv
package coding_pkg;

    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned QUIET_W    = 16;
    localparam int unsigned CNT_W      = 8;

    // ------------------------------------------------------------
    // bit periods in carrier cycles
    // ------------------------------------------------------------
    localparam logic [7:0] BIT_CYC_106 = 8'h80;
    localparam logic [7:0] BIT_CYC_212 = 8'h40;
    localparam logic [7:0] BIT_CYC_424 = 8'h20;
    // carrier/4 gives about 3.39 Mbit/s
    localparam logic [7:0] BIT_CYC_HS  = 8'h04;
    // counter bit that toggles every 8 carrier cycles: carrier/16
    localparam int unsigned SUBC_BIT   = 3;
    localparam logic [3:0] BITS_PAR    = 4'h9;
    localparam logic [3:0] BITS_NOPAR  = 4'h8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        rate_106,
        rate_212,
        rate_424,
        rate_hs
    } rate_t;

    typedef enum logic {
        scheme_a,       // modified miller in, subcarrier reply
        scheme_m        // manchester both ways, no subcarrier
    } scheme_t;

    typedef enum {
        st_target,
        st_quiet,
        st_init,
        st_initiator
    } role_t;

    typedef struct packed {
        rate_t   rate;
        scheme_t scheme;
        logic    active_mode;
    } link_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic       parity_err;
    } rx_word_t;

endpackage : coding_pkg

// >>> hw/contactless_mode_coding_policy.sv
`timescale 1ns/1ps

module sync_fifo #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic         core_clk,  // clock
    input  wire logic         srst,      // sync reset
    input  wire logic [W-1:0] in_data,   // write word
    input  wire logic         in_valid,  // write request
    output logic              in_ready,  // not full
    output logic [W-1:0]      out_data,  // head word
    output logic              out_valid, // not empty
    input  wire logic         out_ready  // head taken
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          room_q;
    logic          empty_q;

    wire logic          push   = in_valid && room_q;
    wire logic          pop    = out_ready && !empty_q;
    wire logic [AW:0]   cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    assign in_ready  = room_q;
    assign out_valid = !empty_q;
    assign out_data  = mem[rd_q];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            room_q  <= 1'b1;
            empty_q <= 1'b1;
        end else begin
            wr_q    <= wr_q + AW'(push);
            rd_q    <= rd_q + AW'(pop);
            cnt_q   <= cnt_d;
            room_q  <= cnt_d != (AW+1)'(DEPTH);
            empty_q <= cnt_d == '0;
        end
    end
endmodule : sync_fifo

// Overview of operation
// R1: a started transaction runs to its end before another may begin
// R2: bit rate and mode are not changed while a transfer is running
// R3: by default sit in target role with own rf field off
// R4: keep rf level detector running while waiting as target
// R5: become initiator only on explicit request from the controller
// R6: field on only after a whole quiet window with no external field
// R7: after field on, start initialization for selected mode and rate
// R8: card replies use load modulation, 14443a or manchester-only scheme
// R9: 14443a receive decodes modified miller at 128, 64, 32 cycle bits
// R10: 14443a reply on carrier/16 subcarrier, manchester 106, bpsk above
// R11: manchester-only receive decodes manchester at 64 or 32 cycle bits
// R12: manchester-only reply is manchester load modulation at command rate
// R13: generate byte framing with parity and check it on receive; the code does both for 14443a only
// R14: high rate baseband path via external modulator pins
// R15: carrier tick is the crystal reference tick halved
// R16: quiet window length is a configurable carrier cycle count
module contactless_mode_coding_policy (
    input  wire logic                  core_clk,          // 20 mhz clock
    input  wire logic                  srst,              // sync reset
    input  wire coding_pkg::link_cfg_t cfg,               // rate and scheme
    input  wire logic                  card_mode,         // card emulation
    input  wire logic                  initiator_req,     // go initiator
    input  wire logic                  initiator_release, // back to target
    input  wire logic                  txn_done,          // transaction end
    input  wire logic [15:0]           quiet_window,      // carrier cycles
    input  wire logic                  rf_ref_tick,       // reference tick
    input  wire logic                  field_detect,      // external field
    input  wire logic                  rx_frame,          // command present
    input  wire logic                  rx_env,            // 0 = pause
    input  wire logic                  ext_demod_data_in, // hs baseband in
    input  wire logic [7:0]            tx_data,           // reply byte
    input  wire logic                  tx_valid,          // reply byte valid
    output logic                       tx_ready,          // fifo has room
    output coding_pkg::rx_word_t       rx_word,           // received byte
    output logic                       rx_word_valid,     // byte strobe
    output logic                       rf_field_on,       // own field
    output logic                       level_det_en,      // detector on
    output logic                       initiator_role,    // role flag
    output logic                       init_start,        // init pulse
    output coding_pkg::link_cfg_t      init_cfg,          // init settings
    output logic                       load_mod,          // load modulation
    output logic                       ext_mod_data_out,  // hs baseband out
    output logic                       busy               // transfer running
);
    // ------------------------------------------------------------
    // carrier enable and configuration
    // ------------------------------------------------------------
    coding_pkg::role_t     role_q;
    coding_pkg::link_cfg_t cfg_q;
    logic                  car_ph_q;
    logic                  txn_q;
    logic                  busy_q;
    logic                  tx_act_q;

    // R15: carrier halved
    wire logic car_tick = rf_ref_tick && car_ph_q;

    wire logic [7:0] bit_cyc =
        (cfg_q.rate == coding_pkg::rate_106) ? coding_pkg::BIT_CYC_106 :
        (cfg_q.rate == coding_pkg::rate_212) ? coding_pkg::BIT_CYC_212 :
        (cfg_q.rate == coding_pkg::rate_424) ? coding_pkg::BIT_CYC_424 :
                                               coding_pkg::BIT_CYC_HS;
    wire logic [7:0] half_cyc = {1'b0, bit_cyc[7:1]};
    wire logic       is_hs    = cfg_q.rate == coding_pkg::rate_hs;
    wire logic       is_a     = cfg_q.scheme == coding_pkg::scheme_a;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            car_ph_q <= 1'b0;
            cfg_q    <= '0;
            busy_q   <= 1'b0;
        end else begin
            if (rf_ref_tick) begin
                car_ph_q <= !car_ph_q;
            end
            // R2: rate frozen mid transfer
            if (!busy_q) begin
                cfg_q <= cfg;
            end
            busy_q <= rx_frame || tx_act_q || txn_q;
        end
    end
    assign busy = busy_q;

    // ------------------------------------------------------------
    // start-up policy
    // ------------------------------------------------------------
    logic [15:0] quiet_cnt_q;
    logic        field_on_q;
    logic        init_q;
    wire logic   quiet_done = quiet_cnt_q >= quiet_window;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            // R3: target with field off
            role_q      <= coding_pkg::st_target;
            quiet_cnt_q <= '0;
            field_on_q  <= 1'b0;
            init_q      <= 1'b0;
            txn_q       <= 1'b0;
        end else begin
            init_q <= 1'b0;
            if (txn_done) begin
                txn_q <= 1'b0;
            end
            case (role_q)
                coding_pkg::st_target: begin
                    quiet_cnt_q <= '0;
                    // R5: only on request
                    if (initiator_req && !card_mode && !busy_q) begin
                        role_q <= coding_pkg::st_quiet;
                    end
                end
                coding_pkg::st_quiet: begin
                    // R6: any field restarts window
                    if (field_detect) begin
                        quiet_cnt_q <= '0;
                    end else if (quiet_done) begin
                        role_q <= coding_pkg::st_init;
                    end else if (car_tick) begin
                        // R16: counted in carrier cycles
                        quiet_cnt_q <= quiet_cnt_q + 16'h0001;
                    end
                    if (initiator_release) begin
                        role_q <= coding_pkg::st_target;
                    end
                end
                coding_pkg::st_init: begin
                    // R6: last look before switching on
                    if (field_detect) begin
                        quiet_cnt_q <= '0;
                        role_q      <= coding_pkg::st_quiet;
                    end else begin
                        // R7: init with selected mode
                        field_on_q <= 1'b1;
                        init_q     <= 1'b1;
                        txn_q      <= 1'b1;
                        role_q     <= coding_pkg::st_initiator;
                    end
                end
                coding_pkg::st_initiator: begin
                    // R1: release waits for transaction end
                    if (initiator_release && !txn_q) begin
                        field_on_q <= 1'b0;
                        role_q     <= coding_pkg::st_target;
                    end
                end
                default: role_q <= coding_pkg::st_target;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rf_field_on    <= 1'b0;
            level_det_en   <= 1'b1;
            initiator_role <= 1'b0;
            init_start     <= 1'b0;
            init_cfg       <= '0;
        end else begin
            rf_field_on    <= field_on_q;
            // R4: detector stays on unless own field is up
            level_det_en   <= !field_on_q;
            initiator_role <= role_q == coding_pkg::st_initiator;
            init_start     <= init_q;
            if (init_q) begin
                init_cfg <= cfg_q;
            end
        end
    end

    // ------------------------------------------------------------
    // receive decoder
    // ------------------------------------------------------------
    logic [7:0] rx_cnt_q;
    logic       pause_lo_q;
    logic       pause_hi_q;
    logic [8:0] rx_sh_q;
    logic [3:0] rx_bits_q;
    // R14: external demodulator at high rate
    wire logic  env        = is_hs ? ext_demod_data_in : rx_env;
    wire logic  rx_second  = rx_cnt_q >= half_cyc;
    wire logic  rx_bit_end = car_tick && (rx_cnt_q == bit_cyc - 8'h01);
    wire logic  pause_hi   = pause_hi_q || (rx_second && !env);
    // R9: miller, pause in second half is one
    // R11: manchester, modulated first half is one
    wire logic  rx_bit     = is_a ? pause_hi : pause_lo_q;
    wire logic [3:0] frame_bits = is_a ? coding_pkg::BITS_PAR
                                       : coding_pkg::BITS_NOPAR;
    wire logic [8:0] rx_sh_d = is_a ? {rx_bit, rx_sh_q[8:1]}
                                    : {1'b0, rx_bit, rx_sh_q[7:1]};

    always_ff @(posedge core_clk) begin
        if (srst || !rx_frame) begin
            rx_cnt_q   <= '0;
            pause_lo_q <= 1'b0;
            pause_hi_q <= 1'b0;
            rx_bits_q  <= '0;
            rx_sh_q    <= '0;
        end else if (car_tick) begin
            if (rx_bit_end) begin
                rx_cnt_q   <= '0;
                pause_lo_q <= 1'b0;
                pause_hi_q <= 1'b0;
                rx_sh_q    <= rx_sh_d;
                rx_bits_q  <= (rx_bits_q + 4'h1 == frame_bits)
                              ? 4'h0 : rx_bits_q + 4'h1;
            end else begin
                rx_cnt_q   <= rx_cnt_q + 8'h01;
                pause_lo_q <= pause_lo_q || (!rx_second && !env);
                pause_hi_q <= pause_hi;
            end
        end
    end

    wire logic rx_byte_end = rx_frame && rx_bit_end
                             && (rx_bits_q + 4'h1 == frame_bits);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_word       <= '0;
            rx_word_valid <= 1'b0;
        end else begin
            rx_word_valid <= rx_byte_end;
            if (rx_byte_end) begin
                rx_word.data       <= rx_sh_d[7:0];
                // R13: odd parity check
                rx_word.parity_err <= is_a && !(^rx_sh_d);
            end
        end
    end

    // ------------------------------------------------------------
    // reply fifo and encoder
    // ------------------------------------------------------------
    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic [7:0] tx_cnt_q;
    logic [8:0] tx_sh_q;
    logic [3:0] tx_bits_q;

    wire logic tx_ok     = (card_mode || initiator_role) && !rx_frame;
    wire logic tx_bit_end = car_tick && (tx_cnt_q == bit_cyc - 8'h01);
    wire logic tx_last   = tx_bits_q == 4'h1;
    wire logic tx_load   = fifo_valid && tx_ok
                           && (!tx_act_q || (tx_bit_end && tx_last));
    wire logic tx_second = tx_cnt_q >= half_cyc;
    wire logic subc      = tx_cnt_q[coding_pkg::SUBC_BIT];
    wire logic tx_bit    = tx_sh_q[0];

    // R8: reply scheme select
    // R10: manchester on subcarrier at 106, bpsk above
    // R12: plain manchester at command rate
    wire logic lm_d =
        !tx_act_q                              ? 1'b0 :
        !is_a                                  ? tx_bit ^ tx_second :
        (cfg_q.rate == coding_pkg::rate_106)   ? subc && (tx_bit ^ tx_second)
                                               : subc ^ !tx_bit;

    sync_fifo #(
        .W     (coding_pkg::BYTE_W),
        .DEPTH (coding_pkg::FIFO_DEPTH)
    ) u_reply_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (tx_load)
    );

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_act_q  <= 1'b0;
            tx_cnt_q  <= '0;
            tx_sh_q   <= '0;
            tx_bits_q <= '0;
        end else if (tx_load) begin
            // R13: odd parity framing
            tx_act_q  <= 1'b1;
            tx_cnt_q  <= '0;
            tx_sh_q   <= {~^fifo_data, fifo_data};
            tx_bits_q <= frame_bits;
        end else if (tx_bit_end && tx_act_q) begin
            tx_cnt_q  <= '0;
            tx_sh_q   <= {1'b0, tx_sh_q[8:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
            tx_act_q  <= !tx_last;
        end else if (car_tick && tx_act_q) begin
            tx_cnt_q <= tx_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            load_mod         <= 1'b0;
            ext_mod_data_out <= 1'b0;
        end else begin
            load_mod         <= !is_hs && lm_d;
            // R14: baseband to external modulator
            ext_mod_data_out <= is_hs && tx_act_q && (tx_bit ^ tx_second);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence quiet_seen_s;
        role_q == coding_pkg::st_quiet && quiet_done && !field_detect;
    endsequence

    field_off_default_a: assert property ( // R3
        role_q == coding_pkg::st_target && !initiator_role
            |=> !field_on_q || $past(role_q) == coding_pkg::st_initiator)
        else $error("field on while in target role");
    det_on_target_a: assert property ( // R4
        role_q == coding_pkg::st_target ##1 !field_on_q |=> level_det_en)
        else $error("level detector off in target role");
    role_by_request_a: assert property ( // R5
        role_q == coding_pkg::st_target && !initiator_req
            |=> role_q == coding_pkg::st_target)
        else $error("left target role without request");
    quiet_before_on_a: assert property ( // R6
        $rose(field_on_q) |-> $past(role_q) == coding_pkg::st_init
            && !$past(field_detect))
        else $error("field switched on without quiet check");
    quiet_gate_a: assert property ( // R6
        quiet_seen_s |=> role_q == coding_pkg::st_init ##1 field_on_q
            || role_q == coding_pkg::st_quiet)
        else $error("quiet window did not lead to init");
    init_follows_a: assert property ( // R7
        $rose(field_on_q) |=> init_start ##1 init_cfg == $past(cfg_q, 2))
        else $error("init not started with selected mode");
    txn_hold_a: assert property ( // R1
        txn_q && role_q == coding_pkg::st_initiator
            |=> role_q == coding_pkg::st_initiator)
        else $error("transaction interrupted");
    rate_stable_a: assert property ( // R2
        busy_q |=> $stable(cfg_q))
        else $error("rate changed during transfer");
    carrier_half_a: assert property ( // R15
        rf_ref_tick && !car_ph_q |=> !rf_ref_tick || car_tick)
        else $error("carrier tick not every second reference");
    tx_parity_a: assert property ( // R13
        tx_load && is_a |=> ^tx_sh_q && tx_bits_q == coding_pkg::BITS_PAR)
        else $error("reply byte not framed with odd parity");
endmodule : contactless_mode_coding_policy

// >>> sim/rf_peer_model.sv
`timescale 1ns/1ps

module rf_peer_model (
    input  wire logic core_clk,     // clock
    output logic      rf_ref_tick,  // reference tick
    output logic      field_detect, // external field
    output logic      rx_frame,     // command present
    output logic      rx_env        // 0 = pause
);
    initial begin
        rf_ref_tick  = 1'b0;
        field_detect = 1'b0;
        rx_frame     = 1'b0;
        rx_env       = 1'b1;
    end

    always @(posedge core_clk) begin
        rf_ref_tick <= ~rf_ref_tick;
    end

    task automatic set_field(input logic on);
        @(posedge core_clk);
        field_detect <= on;
    endtask : set_field

    // one rate per frame, lsb first
    task automatic send_byte(input logic [7:0] d, input logic miller,
                             input int half);
        logic [8:0] bits;
        int         n;
        bits = {~^d, d};
        n = miller ? 9 : 8;
        @(posedge core_clk);
        rx_frame <= 1'b1;
        for (int i = 0; i < n; i++) begin
            rx_env <= miller ? 1'b1 : ~bits[i];
            repeat (half) @(posedge core_clk);
            rx_env <= miller ? ~bits[i] : bits[i];
            repeat (half) @(posedge core_clk);
        end
        rx_env <= 1'b1;
        repeat (8) @(posedge core_clk);
        rx_frame <= 1'b0;
    endtask : send_byte
endmodule : rf_peer_model

// >>> sim/contactless_mode_coding_policy_tb.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    err_count++; $display("ERROR at %0t: got %0h expected %0h", \
    $time, (got), (exp)); end end

module contactless_mode_coding_policy_tb;
    logic                  core_clk = 1'b0;
    logic                  srst = 1'b1;
    coding_pkg::link_cfg_t cfg = '0;
    logic                  card_mode = 1'b0;
    logic                  initiator_req = 1'b0;
    logic                  initiator_release = 1'b0;
    logic                  txn_done = 1'b0;
    logic [15:0]           quiet_window = 16'h0004;
    logic [7:0]            tx_data = 8'h00;
    logic                  tx_valid = 1'b0;
    logic                  rf_ref_tick, field_detect, rx_frame, rx_env;
    logic                  tx_ready, rx_word_valid, rf_field_on;
    logic                  level_det_en, initiator_role, init_start;
    logic                  load_mod, ext_mod_data_out, busy;
    coding_pkg::rx_word_t  rx_word, exp_w;
    coding_pkg::link_cfg_t init_cfg, exp_cfg;
    coding_pkg::rx_word_t  rx_q[$];
    int                    err_count = 0;
    int                    checked = 0;
    int                    lm_edges = 0;
    int                    ext_edges = 0;
    int                    n, e0, x0;
    logic                  lm_prev = 1'b0;
    logic                  ext_prev = 1'b0;

    always #25 core_clk = ~core_clk;

    rf_peer_model i_peer (.core_clk(core_clk), .rf_ref_tick(rf_ref_tick),
        .field_detect(field_detect), .rx_frame(rx_frame), .rx_env(rx_env));

    contactless_mode_coding_policy i_dut (.core_clk(core_clk), .srst(srst),
        .cfg(cfg), .card_mode(card_mode), .initiator_req(initiator_req),
        .initiator_release(initiator_release), .txn_done(txn_done),
        .quiet_window(quiet_window), .rf_ref_tick(rf_ref_tick),
        .field_detect(field_detect), .rx_frame(rx_frame), .rx_env(rx_env),
        .ext_demod_data_in(rx_env), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid), .rf_field_on(rf_field_on),
        .level_det_en(level_det_en), .initiator_role(initiator_role),
        .init_start(init_start), .init_cfg(init_cfg), .load_mod(load_mod),
        .ext_mod_data_out(ext_mod_data_out), .busy(busy));

    // ------------------------------------------------------------
    // output watcher
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        lm_prev  <= load_mod;
        ext_prev <= ext_mod_data_out;
        if (load_mod !== lm_prev) lm_edges++;
        if (ext_mod_data_out !== ext_prev) ext_edges++;
        if (!srst && rx_word_valid === 1'b1) begin
            if (rx_q.size() == 0) begin
                `CHK(1'b1, 1'b0)
            end else begin
                exp_w = rx_q.pop_front();
                `CHK(rx_word, exp_w)
            end
        end
        if (!srst && init_start === 1'b1) begin
            `CHK(init_cfg, exp_cfg)
            `CHK(rf_field_on, 1'b1)
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic int bit_cyc(input coding_pkg::rate_t r);
        case (r)
            coding_pkg::rate_106: return int'(coding_pkg::BIT_CYC_106);
            coding_pkg::rate_212: return int'(coding_pkg::BIT_CYC_212);
            coding_pkg::rate_hs:  return int'(coding_pkg::BIT_CYC_HS);
            default:              return int'(coding_pkg::BIT_CYC_424);
        endcase
    endfunction : bit_cyc

    // 0 request, 1 release, 2 transaction end
    task automatic pulse(input int k);
        for (int v = 1; v >= 0; v--) begin
            case (k)
                0:       initiator_req     <= v[0];
                1:       initiator_release <= v[0];
                default: txn_done          <= v[0];
            endcase
            @(posedge core_clk);
        end
    endtask : pulse

    // waits for the transmit side to finish, bounded
    task automatic wait_idle();
        repeat (4) @(posedge core_clk);
        n = 0;
        while (busy !== 1'b0 && n < 40000) begin
            @(posedge core_clk);
            n++;
        end
        `CHK(busy, 1'b0)
    endtask : wait_idle

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    initial begin
        #(50 * 90000);
        err_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        coding_pkg::rate_t   rt[6];
        coding_pkg::scheme_t sc[6];
        logic [7:0]          d;
        rt = '{coding_pkg::rate_106, coding_pkg::rate_212,
               coding_pkg::rate_424, coding_pkg::rate_212,
               coding_pkg::rate_424, coding_pkg::rate_hs};
        sc = '{coding_pkg::scheme_a, coding_pkg::scheme_a,
               coding_pkg::scheme_a, coding_pkg::scheme_m,
               coding_pkg::scheme_m, coding_pkg::scheme_m};
        void'($urandom(32'h7ee00272));
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        `CHK(rf_field_on, 1'b0)
        `CHK(level_det_en, 1'b1)
        `CHK(initiator_role, 1'b0)
        `CHK(tx_ready, 1'b1)
        card_mode <= 1'b1;
        pulse(0);
        repeat (40) @(posedge core_clk);
        `CHK(initiator_role, 1'b0)
        card_mode <= 1'b0;
        i_peer.set_field(1'b1);
        cfg <= {coding_pkg::rate_212, coding_pkg::scheme_m, 1'b1};
        exp_cfg = {coding_pkg::rate_212, coding_pkg::scheme_m, 1'b1};
        pulse(0);
        repeat (80) @(posedge core_clk);
        `CHK(rf_field_on, 1'b0)
        i_peer.set_field(1'b0);
        n = 0;
        while (init_start !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        `CHK(n >= 16 && n < 24, 1'b1)
        `CHK(level_det_en, 1'b0)
        pulse(1);
        repeat (10) @(posedge core_clk);
        `CHK(initiator_role, 1'b1)
        pulse(2);
        pulse(1);
        repeat (3) @(posedge core_clk);
        `CHK(initiator_role, 1'b0)
        `CHK(level_det_en, 1'b1)
        $display("test policy done");

        for (int i = 0; i < 6; i++) begin
            cfg <= {rt[i], sc[i], 1'b0};
            d = 8'($urandom);
            repeat (2) @(posedge core_clk);
            rx_q.push_back({d, 1'b0});
            i_peer.send_byte(d, sc[i] == coding_pkg::scheme_a,
                             2 * bit_cyc(rt[i]));
            repeat (20) @(posedge core_clk);
        end
        `CHK(rx_q.size(), 0)
        $display("test receive done");

        cfg <= {coding_pkg::rate_424, coding_pkg::scheme_m, 1'b0};
        tx_valid <= 1'b1;
        n = 0;
        for (int i = 0; i < 24; i++) begin
            @(negedge core_clk);
            if (tx_ready === 1'b1) n++;
            @(posedge core_clk);
            tx_data <= 8'($urandom);
        end
        tx_valid <= 1'b0;
        `CHK(n, int'(coding_pkg::FIFO_DEPTH))
        d = 8'($urandom);
        rx_q.push_back({d, 1'b0});
        e0 = lm_edges;
        i_peer.send_byte(d, 1'b0, 2 * bit_cyc(coding_pkg::rate_424));
        `CHK(tx_ready, 1'b0)
        card_mode <= 1'b1;
        wait_idle();
        `CHK(tx_ready, 1'b1)
        `CHK((lm_edges - e0) >= 128 && (lm_edges - e0) <= 257, 1'b1)
        $display("test buffer done");

        cfg <= {coding_pkg::rate_106, coding_pkg::scheme_a, 1'b0};
        @(posedge core_clk);
        e0 = lm_edges;
        tx_data <= 8'($urandom);
        tx_valid <= 1'b1;
        @(posedge core_clk);
        tx_valid <= 1'b0;
        wait_idle();
        `CHK((lm_edges - e0) >= 64, 1'b1)
        cfg <= {coding_pkg::rate_hs, coding_pkg::scheme_m, 1'b0};
        @(posedge core_clk);
        e0 = lm_edges;
        x0 = ext_edges;
        tx_data <= 8'($urandom);
        tx_valid <= 1'b1;
        @(posedge core_clk);
        tx_valid <= 1'b0;
        wait_idle();
        `CHK(lm_edges - e0, 0)
        `CHK((ext_edges - x0) >= 8, 1'b1)
        $display("test transmit done");
        report_and_stop();
    end
endmodule : contactless_mode_coding_policy_tb
